// file: rrn_pkg.sv
package rrn_pkg;
  // ****************************************
  // widths
  // ****************************************
  localparam int INSTR_W = 14;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int OPHI_W = 6;
  // ****************************************
  // opcode fields
  // ****************************************
  localparam int OPHI_LSB = 8;
  localparam int DEST_BIT = 7;
  localparam logic [INSTR_W-1:0] OPC_NO_OPERATION = 14'h0000;
  localparam logic [INSTR_W-1:0] OPC_SUBROUTINE_RETURN = 14'h0040;
  localparam logic [INSTR_W-1:0] OPC_INTERRUPT_RETURN = 14'h0060;
  localparam logic [OPHI_W-1:0] OPHI_LITERAL_RETURN = 6'h18;
  localparam logic [OPHI_W-1:0] OPHI_ROTATE_LEFT = 6'h0d;
  localparam logic [OPHI_W-1:0] OPHI_ROTATE_RIGHT = 6'h0c;
  localparam logic DEST_W_REG = 1'b0;
  localparam logic DEST_FILE = 1'b1;
  // ****************************************
  // cycle counts
  // ****************************************
  localparam int RETURN_CYCLES = 2;
  localparam int ROTATE_CYCLES = 1;
  localparam int NOP_CYCLES = 1;

  typedef enum {RRN_IDLE, RRN_RET_SECOND} rrn_state_t;
endpackage

// file: rrn_rot_if.sv
interface rrn_rot_if #(parameter int WIDTH = 8);
  logic [WIDTH-1:0] operand;
  logic carry_in;
  logic left;
  logic [WIDTH-1:0] result;
  logic carry_out;

  modport user (output operand, output carry_in, output left,
                input result, input carry_out);
  modport rotator (input operand, input carry_in, input left,
                   output result, output carry_out);
endinterface

// file: rrn_rotate.sv
module rrn_rotate (
  rrn_rot_if.rotator rot // operand in, rotated value out
);
  // ****************************************
  // rotate through carry, one bit
  // ****************************************
  localparam int W = $bits(rot.operand);
  wire [W-1:0] left_val = {rot.operand[W-2:0], rot.carry_in};
  wire [W-1:0] right_val = {rot.carry_in, rot.operand[W-1:1]};

  assign rot.result = rot.left ? left_val : right_val;
  assign rot.carry_out = rot.left ? rot.operand[W-1] : rot.operand[0];
endmodule

// file: rrn_decode.sv
// What this block does
// - The subroutine return pops the stack, loads the popped top entry into the program counter and occupies two cycles.
// - The interrupt return pops the stack and loads the popped top entry into the program counter.
// - The interrupt return also sets the global interrupt enable and occupies two cycles.
// - The literal return loads its low-byte literal into the working register, pops the stack into the program counter and occupies two cycles.
// - Rotate left moves the file register up one bit, old carry into bit 0, old bit 7 into carry, in one cycle.
// - Rotate left writes the working register when the destination bit is zero and the file register when it is one.
// - Rotate right moves the file register down one bit, old carry into bit 7, old bit 0 into carry, in one cycle.
// - Both rotates take a seven-bit file address in the low bits and the destination bit just above it.
// - Rotate right writes the working register when the destination bit is zero and the file register when it is one.
module rrn_decode
  import rrn_pkg::*;
#(
  parameter int PC_W = 11
) (
  input wire logic CLK, // core clock
  input wire logic ARST_N, // async reset, active low
  input wire logic [INSTR_W-1:0] INSTR, // instruction word
  input wire logic INSTR_VALID, // instruction offered
  output logic READY, // instruction taken when high
  output logic UNSUPPORTED, // opcode outside this group
  output logic PC_INC, // advance program counter
  output logic PC_LOAD, // load program counter
  output logic [PC_W-1:0] PC_VALUE, // value for program counter
  output logic STACK_POP, // pop return stack
  input wire logic [PC_W-1:0] STACK_TOP, // current stack top entry
  output logic GLOBAL_IRQ_ENABLE_SET, // set interrupt enable
  output logic [FADDR_W-1:0] F_RADDR, // file read address
  input wire logic [DATA_W-1:0] F_RDATA, // file read data, same cycle
  output logic F_WE, // file write strobe
  output logic [FADDR_W-1:0] F_WADDR, // file write address
  output logic [DATA_W-1:0] F_WDATA, // file write data
  output logic W_WE, // working register write strobe
  output logic [DATA_W-1:0] W_DATA, // working register data
  input wire logic CARRY_IN, // current carry flag
  output logic CARRY_WE, // carry write strobe
  output logic CARRY_OUT // new carry flag
);
  // ****************************************
  // decode
  // ****************************************
  rrn_state_t state, next_state;
  wire [OPHI_W-1:0] op_hi = INSTR[INSTR_W-1:OPHI_LSB];
  wire take = INSTR_VALID && READY;
  wire is_nop = (INSTR == OPC_NO_OPERATION);
  wire is_sub_ret = (INSTR == OPC_SUBROUTINE_RETURN);
  wire is_irq_ret = (INSTR == OPC_INTERRUPT_RETURN);
  wire is_lit_ret = (op_hi == OPHI_LITERAL_RETURN);
  wire is_rol = (op_hi == OPHI_ROTATE_LEFT);
  wire is_ror = (op_hi == OPHI_ROTATE_RIGHT);
  wire is_ret = is_sub_ret || is_irq_ret || is_lit_ret;
  wire is_rot = is_rol || is_ror;
  wire dest_file = INSTR[DEST_BIT];
  wire take_ret = take && is_ret;
  wire take_rot = take && is_rot;

  assign READY = (state == RRN_IDLE);
  assign F_RADDR = INSTR[FADDR_W-1:0];

  rrn_rot_if #(.WIDTH(DATA_W)) rot ();
  assign rot.operand = F_RDATA;
  assign rot.carry_in = CARRY_IN;
  assign rot.left = is_rol;
  rrn_rotate u_rotate (.rot(rot));

  // ****************************************
  // sequencing
  // ****************************************
  always_comb begin
    next_state = state;
    case (state)
      RRN_IDLE: begin
        if (take_ret) begin
          next_state = RRN_RET_SECOND;
        end
      end
      RRN_RET_SECOND: begin
        next_state = RRN_IDLE;
      end
      default: begin
        next_state = RRN_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state <= RRN_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************
  // program counter and stack
  // ****************************************
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      PC_INC <= 1'b0;
      PC_LOAD <= 1'b0;
      PC_VALUE <= '0;
      STACK_POP <= 1'b0;
      GLOBAL_IRQ_ENABLE_SET <= 1'b0;
      UNSUPPORTED <= 1'b0;
    end else begin
      PC_INC <= take && (is_nop || is_rot);
      PC_LOAD <= take_ret;
      STACK_POP <= take_ret;
      if (take_ret) begin
        PC_VALUE <= STACK_TOP;
      end
      GLOBAL_IRQ_ENABLE_SET <= take && is_irq_ret;
      UNSUPPORTED <= take && !(is_nop || is_ret || is_rot);
    end
  end

  // ****************************************
  // data path
  // ****************************************
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      W_WE <= 1'b0;
      W_DATA <= '0;
      F_WE <= 1'b0;
      F_WADDR <= '0;
      F_WDATA <= '0;
      CARRY_WE <= 1'b0;
      CARRY_OUT <= 1'b0;
    end else begin
      W_WE <= (take && is_lit_ret) || (take_rot && !dest_file);
      F_WE <= take_rot && dest_file;
      CARRY_WE <= take_rot;
      if (take && is_lit_ret) begin
        W_DATA <= INSTR[DATA_W-1:0];
      end else if (take_rot) begin
        W_DATA <= rot.result;
      end
      if (take_rot) begin
        F_WADDR <= INSTR[FADDR_W-1:0];
        F_WDATA <= rot.result;
        CARRY_OUT <= rot.carry_out;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  sequence take_ret_s;
    INSTR_VALID && READY && is_ret;
  endsequence
  sequence ret_busy_s;
    !READY ##1 READY;
  endsequence

  ret_pop_pc_a: assert property (
    take_ret_s |=> STACK_POP && PC_LOAD && PC_VALUE == $past(STACK_TOP))
    else $error("return did not pop stack into pc");
  ret_two_cyc_a: assert property (
    take_ret_s |=> ret_busy_s)
    else $error("return not two cycles");
  irq_ret_a: assert property (
    INSTR_VALID && READY && is_irq_ret
      |=> GLOBAL_IRQ_ENABLE_SET && STACK_POP && !PC_INC)
    else $error("interrupt return wrong");
  lit_ret_a: assert property (
    INSTR_VALID && READY && is_lit_ret
      |=> W_WE && W_DATA == $past(INSTR[DATA_W-1:0]) && STACK_POP)
    else $error("literal return wrong");
  rol_value_a: assert property (
    INSTR_VALID && READY && is_rol |=> CARRY_WE
      && CARRY_OUT == $past(F_RDATA[DATA_W-1])
      && F_WDATA == {$past(F_RDATA[DATA_W-2:0]), $past(CARRY_IN)})
    else $error("rotate left value wrong");
  ror_value_a: assert property (
    INSTR_VALID && READY && is_ror |=> CARRY_WE && READY
      && CARRY_OUT == $past(F_RDATA[0])
      && F_WDATA == {$past(CARRY_IN), $past(F_RDATA[DATA_W-1:1])})
    else $error("rotate right value wrong");
  rol_dest_a: assert property (
    INSTR_VALID && READY && is_rol
      |=> (F_WE == $past(dest_file)) && (W_WE != $past(dest_file)))
    else $error("rotate left destination wrong");
  ror_dest_a: assert property (
    INSTR_VALID && READY && is_ror && !dest_file
      |=> W_WE && !F_WE && W_DATA == F_WDATA)
    else $error("rotate right destination wrong");
  rot_addr_a: assert property (
    INSTR_VALID && READY && is_rot
      |=> F_WADDR == $past(INSTR[FADDR_W-1:0]))
    else $error("rotate file address wrong");
  nop_quiet_a: assert property (
    INSTR_VALID && READY && is_nop |=> PC_INC && READY && !W_WE
      && !F_WE && !CARRY_WE && !STACK_POP && !PC_LOAD)
    else $error("no-operation changed state");
  sub_ret_quiet_a: assert property (
    INSTR_VALID && READY && is_sub_ret |=> PC_LOAD
      && !GLOBAL_IRQ_ENABLE_SET && !W_WE && !F_WE
      && !CARRY_WE && !PC_INC)
    else $error("subroutine return side effect");
  ret_refused_a: assert property (
    !READY |=> !STACK_POP && !PC_LOAD && !PC_INC && !W_WE && !F_WE
      && !CARRY_WE && !GLOBAL_IRQ_ENABLE_SET && !UNSUPPORTED)
    else $error("instruction taken in second return cycle");
  irq_set_only_a: assert property (
    INSTR_VALID && READY && !is_irq_ret |=> !GLOBAL_IRQ_ENABLE_SET)
    else $error("interrupt enable set by other opcode");
  rot_one_cyc_a: assert property (
    INSTR_VALID && READY && is_rot |=> READY && PC_INC && !STACK_POP
      && !PC_LOAD)
    else $error("rotate not one cycle");
  ror_file_a: assert property (
    INSTR_VALID && READY && is_ror && dest_file
      |=> F_WE && !W_WE && F_WDATA == {$past(CARRY_IN),
      $past(F_RDATA[DATA_W-1:1])})
    else $error("rotate right to file wrong");
  unsup_alone_a: assert property (
    INSTR_VALID && READY && !(is_nop || is_ret || is_rot)
      |=> UNSUPPORTED && !PC_INC && !PC_LOAD && !STACK_POP && !W_WE
      && !F_WE && !CARRY_WE)
    else $error("unsupported opcode had an effect");
endmodule

// file: rrn_decode_tb.sv
module rrn_decode_tb
  import rrn_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // stimulus and design
  // ****************************************
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [INSTR_W-1:0] instr = '0;
  logic valid = 1'b0;
  logic [10:0] stack_top = '0;
  logic [DATA_W-1:0] f_rdata = '0;
  logic carry_in = 1'b0;
  logic ready, unsup, pc_inc, pc_load, pop, irq_set, f_we, w_we, c_we, c_out;
  logic [10:0] pc_value;
  logic [FADDR_W-1:0] f_raddr, f_waddr;
  logic [DATA_W-1:0] f_wdata, w_data;
  logic [7:0] pulses;
  int error_cnt = 0;
  int num_checks = 0;
  assign pulses = {pc_inc, pc_load, pop, irq_set, f_we, w_we, c_we, unsup};
  always #2.5 clk = ~clk;
  rrn_decode #(.PC_W(11)) i_dut (.CLK(clk), .ARST_N(arst_n), .INSTR(instr),
    .INSTR_VALID(valid), .READY(ready), .UNSUPPORTED(unsup),
    .PC_INC(pc_inc), .PC_LOAD(pc_load), .PC_VALUE(pc_value),
    .STACK_POP(pop), .STACK_TOP(stack_top), .GLOBAL_IRQ_ENABLE_SET(irq_set),
    .F_RADDR(f_raddr), .F_RDATA(f_rdata), .F_WE(f_we), .F_WADDR(f_waddr),
    .F_WDATA(f_wdata), .W_WE(w_we), .W_DATA(w_data), .CARRY_IN(carry_in),
    .CARRY_WE(c_we), .CARRY_OUT(c_out));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask
  // offer one word; returns just after the take edge, valid left high
  task automatic issue(input logic [13:0] op, input logic [7:0] fd,
                       input logic c, input logic [10:0] top);
    instr = op;
    f_rdata = fd;
    carry_in = c;
    stack_top = top;
    valid = 1'b1;
    #1;
    chk(f_raddr, op[6:0]);
    chk(ready, 1'b1);
    @(posedge clk);
    #1;
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_nop;
    issue(OPC_NO_OPERATION, 8'hff, 1'b1, 11'h7ff);
    chk(pulses, 8'h80);
    issue(14'h0003, 8'hff, 1'b1, 11'h7ff);
    chk(pulses, 8'h01);
    valid = 1'b0;
    @(posedge clk);
    #1;
    chk(pulses, 8'h00);
    $display("test nop done");
  endtask
  task automatic t_return;
    logic [13:0] ops [3];
    logic [10:0] tp;
    logic [7:0] ep;
    ops = '{OPC_SUBROUTINE_RETURN, OPC_INTERRUPT_RETURN,
            {OPHI_LITERAL_RETURN, 8'ha5}};
    for (int k = 0; k < 3; k++) begin
      tp = 11'h5a3 ^ 11'(k * 11'h0ff);
      issue(ops[k], 8'h3c, 1'b1, tp);
      ep = {3'b011, k == 1, 1'b0, k == 2, 2'b00};
      chk(pulses, ep);
      chk(pc_value, tp);
      if (k == 2) chk(w_data, 8'ha5);
      chk(ready, 1'b0);
      @(posedge clk);
      #1;
      chk(pulses, 8'h00);
    end
    valid = 1'b0;
    @(posedge clk);
    #1;
    chk(pulses, 8'h00);
    $display("test return done");
  endtask
  task automatic t_rotate;
    logic lf, d, c;
    logic [6:0] a;
    logic [7:0] fd, res;
    for (int i = 0; i < 8; i++) begin
      {c, d, lf} = 3'(i);
      a = c ? 7'h7f : 7'h00;
      fd = 8'he6 ^ 8'(i * 8'h35);
      res = lf ? {fd[6:0], c} : {c, fd[7:1]};
      issue({lf ? OPHI_ROTATE_LEFT : OPHI_ROTATE_RIGHT, d, a}, fd, c, 11'h0);
      chk(pulses, {4'b1000, d, ~d, 2'b10});
      chk(c_out, lf ? fd[7] : fd[0]);
      if (d) chk({f_waddr, f_wdata}, {a, res});
      else chk(w_data, res);
    end
    valid = 1'b0;
    $display("test rotate done");
  endtask
  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    repeat (4) @(posedge clk);
    #1;
    chk({ready, pulses}, 9'h100);
    arst_n = 1'b1;
    t_nop();
    t_return();
    t_rotate();
    summarize();
  end
  initial begin
    #2000;
    error_cnt++;
    summarize();
  end
endmodule
